/* File: rtl/rgb_port_pkg.sv */
// package: constants and carriers for the parallel rgb display port
// assumes: pixel stream and timing come from an upstream display controller
package rgb_port_pkg;
  localparam int MAX_H = 1920;
  localparam int MAX_V = 1200;
  localparam int BUS_W = 24;
  localparam int COLOR_W = 8;
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_565_PACKED = 3'h0;
  localparam logic [MODE_W-1:0] MODE_666_PACKED = 3'h1;
  localparam logic [MODE_W-1:0] MODE_565_WIDE = 3'h2;
  localparam logic [MODE_W-1:0] MODE_666_WIDE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_888 = 3'h4;
  localparam int CLK_DIV_W = 8;
  localparam logic [CLK_DIV_W-1:0] CLK_DIV_RESET = 8'h02;
  localparam int G_LO_888 = 8;
  localparam int R_LO_888 = 16;
  localparam int G_LO_666 = 6;
  localparam int R_LO_666 = 12;
  localparam int G_LO_565 = 5;
  localparam int R_LO_565 = 11;
  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } pixel_s;
  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic valid;
  } pixel_ctl_s;
endpackage

/* File: rtl/rgb_pixel_mapper.sv */
// mapper: packs one rgb pixel onto the 24 data lines per colour mode
// assumes: mode is steady while pixels flow
`timescale 1ns/1ns
`default_nettype none
module rgb_pixel_mapper (
  input wire logic [rgb_port_pkg::MODE_W-1:0] mode_i,
  input wire rgb_port_pkg::pixel_s pix_i,
  output logic [rgb_port_pkg::BUS_W-1:0] lines_o
);
  always_comb
  begin
    lines_o = '0;
    case (mode_i)
      rgb_port_pkg::MODE_666_PACKED:
      begin
        lines_o[5:0] = pix_i.blue[7:2];
        lines_o[rgb_port_pkg::G_LO_666 +: 6] = pix_i.green[7:2];
        lines_o[rgb_port_pkg::R_LO_666 +: 6] = pix_i.red[7:2];
      end
      rgb_port_pkg::MODE_565_PACKED:
      begin
        lines_o[4:0] = pix_i.blue[7:3];
        lines_o[rgb_port_pkg::G_LO_565 +: 6] = pix_i.green[7:2];
        lines_o[rgb_port_pkg::R_LO_565 +: 5] = pix_i.red[7:3];
      end
      rgb_port_pkg::MODE_666_WIDE:
      begin
        lines_o[7:2] = pix_i.blue[7:2];
        lines_o[15:10] = pix_i.green[7:2];
        lines_o[23:18] = pix_i.red[7:2];
      end
      rgb_port_pkg::MODE_565_WIDE:
      begin
        lines_o[7:3] = pix_i.blue[7:3];
        lines_o[15:10] = pix_i.green[7:2];
        lines_o[23:19] = pix_i.red[7:3];
      end
      default:
      begin
        lines_o[7:0] = pix_i.blue;
        lines_o[rgb_port_pkg::G_LO_888 +: 8] = pix_i.green;
        lines_o[rgb_port_pkg::R_LO_888 +: 8] = pix_i.red;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/parallel_rgb_lcd_port.sv */
// top: parallel rgb panel port with pixel clock and panel side-band pins
// assumes: pixel and controls come from same-clock logic; pins are async
`timescale 1ns/1ns
`default_nettype none
module parallel_rgb_lcd_port #(
  parameter logic [rgb_port_pkg::CLK_DIV_W-1:0] CLK_HALF =
    rgb_port_pkg::CLK_DIV_RESET
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [rgb_port_pkg::MODE_W-1:0] mode_i,
  input wire rgb_port_pkg::pixel_s pixel_i,
  input wire rgb_port_pkg::pixel_ctl_s ctl_i,
  output logic pixel_take_o,
  input wire logic pwm_channel_two_output_i,
  input wire logic backlight_on_i,
  input wire logic panel_on_i,
  input wire logic touch_reset_req_i,
  input wire logic touch_event_in_i,
  output logic touch_event_o,
  output logic [rgb_port_pkg::BUS_W-1:0] pixel_lines_o,
  output logic line_sync_out_o,
  output logic frame_sync_out_o,
  output logic pixel_valid_out_o,
  output logic pixel_clock_out_o,
  output logic backlight_dimming_pwm_o,
  output logic backlight_supply_on_o,
  output logic panel_supply_on_o,
  output logic touch_reset_n_o
);
  logic [rgb_port_pkg::CLK_DIV_W-1:0] div_q;
  logic [rgb_port_pkg::BUS_W-1:0] mapped;
  logic fall;
  logic [1:0] irq_sync_q;
  logic [1:0] pwm_sync_q;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  rgb_pixel_mapper u_map (
    .mode_i(mode_i),
    .pix_i(pixel_i),
    .lines_o(mapped)
  );

  assign fall = pixel_clock_out_o && (div_q == CLK_HALF - 8'h01);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      div_q <= '0;
      pixel_clock_out_o <= 1'b0;
    end
    else if (div_q == CLK_HALF - 8'h01)
    begin
      div_q <= '0;
      pixel_clock_out_o <= ~pixel_clock_out_o;
    end
    else
    begin
      div_q <= div_q + 8'h01;
    end
  end

  // one pixel taken per pixel clock period
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pixel_take_o <= 1'b0;
    end
    else
    begin
      pixel_take_o <= fall;
    end
  end

  // data lines and enable launched on falling edge
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pixel_lines_o <= '0;
      pixel_valid_out_o <= 1'b0;
    end
    else if (fall)
    begin
      pixel_lines_o <= ctl_i.valid ? mapped : '0;
      pixel_valid_out_o <= ctl_i.valid;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      line_sync_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
    end
    else if (fall)
    begin
      line_sync_out_o <= ctl_i.line_sync;
      frame_sync_out_o <= ctl_i.frame_sync;
    end
  end

  // pwm channel resynchronised to the pin
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pwm_sync_q <= '0;
      backlight_dimming_pwm_o <= 1'b0;
    end
    else
    begin
      pwm_sync_q <= {pwm_sync_q[0], pwm_channel_two_output_i};
      backlight_dimming_pwm_o <= pwm_sync_q[1];
    end
  end

  // backlight supply, panel supply, touch reset
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      backlight_supply_on_o <= 1'b0;
      panel_supply_on_o <= 1'b0;
      touch_reset_n_o <= 1'b0;
    end
    else
    begin
      backlight_supply_on_o <= backlight_on_i;
      panel_supply_on_o <= panel_on_i;
      touch_reset_n_o <= ~touch_reset_req_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      irq_sync_q <= '0;
      touch_event_o <= 1'b0;
    end
    else
    begin
      irq_sync_q <= {irq_sync_q[0], touch_event_in_i};
      touch_event_o <= irq_sync_q[1];
    end
  end

  sequence s_fall_valid;
    fall && ctl_i.valid;
  endsequence

  a_valid_follows: assert property (
    s_fall_valid |=> pixel_valid_out_o)
    else $error("valid not launched");
  a_idle_lines_zero: assert property (
    fall && !ctl_i.valid |=> pixel_lines_o == '0)
    else $error("idle lines not zero");
  a_data_stable_high: assert property (
    $rose(pixel_clock_out_o) |-> $stable(pixel_lines_o))
    else $error("data moved on rising clock");
  a_hold_between: assert property (
    !fall |=> $stable(pixel_lines_o) && $stable(pixel_valid_out_o))
    else $error("data moved between falls");
  a_take_once: assert property (
    pixel_take_o |=> !pixel_take_o)
    else $error("take pulse too long");
  a_take_after_fall: assert property (
    fall |=> pixel_take_o)
    else $error("take not raised after fall");
  a_888_map: assert property (
    (s_fall_valid and mode_i == rgb_port_pkg::MODE_888) |=>
      pixel_lines_o == $past(pixel_i))
    else $error("888 mapping wrong");
  a_565_map: assert property (
    (s_fall_valid and mode_i == rgb_port_pkg::MODE_565_PACKED) |=>
      pixel_lines_o[15:0] == {$past(pixel_i.red[7:3]),
      $past(pixel_i.green[7:2]), $past(pixel_i.blue[7:3])})
    else $error("565 mapping wrong");
  a_666_map: assert property (
    (s_fall_valid and mode_i == rgb_port_pkg::MODE_666_PACKED) |=>
      pixel_lines_o[17:0] == {$past(pixel_i.red[7:2]),
      $past(pixel_i.green[7:2]), $past(pixel_i.blue[7:2])})
    else $error("666 mapping wrong");
  a_666_upper_zero: assert property (
    fall && mode_i == rgb_port_pkg::MODE_666_PACKED |=>
      pixel_lines_o[23:18] == 6'h00)
    else $error("666 upper lines driven");
  a_565_upper_zero: assert property (
    fall && mode_i == rgb_port_pkg::MODE_565_PACKED |=>
      pixel_lines_o[23:16] == 8'h00)
    else $error("565 upper lines driven");
  a_666w_low_zero: assert property (
    fall && mode_i == rgb_port_pkg::MODE_666_WIDE |=>
      pixel_lines_o[1:0] == 2'h0 && pixel_lines_o[9:8] == 2'h0)
    else $error("666 wide low lines driven");
  a_565w_low_zero: assert property (
    fall && mode_i == rgb_port_pkg::MODE_565_WIDE |=>
      pixel_lines_o[2:0] == 3'h0 && pixel_lines_o[18:16] == 3'h0)
    else $error("565 wide low lines driven");
  a_sync_follows: assert property (
    fall |=> line_sync_out_o == $past(ctl_i.line_sync))
    else $error("line sync not launched");
  a_fsync_follows: assert property (
    fall |=> frame_sync_out_o == $past(ctl_i.frame_sync))
    else $error("frame sync not launched");
  a_touch_reset: assert property (
    touch_reset_req_i |=> !touch_reset_n_o)
    else $error("touch reset not low");
  a_supply_follow: assert property (
    panel_on_i && backlight_on_i |=>
      panel_supply_on_o && backlight_supply_on_o)
    else $error("supply enables not high");
  a_backlight_off: assert property (
    !backlight_on_i |=> !backlight_supply_on_o)
    else $error("backlight supply not off");
  a_pwm_delay: assert property (
    $rose(pwm_sync_q[1]) |=> backlight_dimming_pwm_o)
    else $error("pwm not forwarded");
  a_irq_delay: assert property (
    $rose(irq_sync_q[1]) |=> touch_event_o)
    else $error("touch event not forwarded");
endmodule
`default_nettype wire

/* File: tb/panel_model.sv */
// panel model: samples data and controls at each pixel clock rise
// assumes: clock_i is fast against the pixel clock it samples
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [23:0] lines_i,
  input wire logic [2:0] ctl_i,
  input wire logic pclk_i,
  input wire logic irq_i,
  output logic touch_event_in_o,
  output logic got_o,
  output logic [26:0] word_o,
  output logic [7:0] per_o
);
  logic pclk_q;
  logic [7:0] cnt_q;
  // touch on first i2c channel, only its irq here
  assign touch_event_in_o = irq_i;
  always_ff @(posedge clock_i)
  begin
    pclk_q <= rst_i ? 1'b0 : pclk_i;
    got_o <= !rst_i && pclk_i && !pclk_q;
    cnt_q <= (pclk_i && !pclk_q) ? 8'h01 : cnt_q + 8'h01;
    if (pclk_i && !pclk_q)
    begin
      word_o <= {ctl_i, lines_i};
      per_o <= cnt_q;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: random pixels in every mode, side-band pipelines
// assumes: panel_model samples the port at pixel clock rises
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int HALF = 4;
  logic clock_i, rst_i, take, tev, ls, fs, pv, pclk, pwm_o, bl_o, pn_o, trn;
  logic pwm, bl, pn, trq, irq, got, ev;
  logic [2:0] mode, cur_mode;
  logic [23:0] lines;
  logic [26:0] word;
  logic [7:0] per;
  logic [4:0] h1, h2, h3;
  logic [26:0] exp_q[$];
  rgb_port_pkg::pixel_s pix;
  rgb_port_pkg::pixel_ctl_s ctl;
  int err_count, tests_run, seed, cyc, takes;
  parallel_rgb_lcd_port #(.CLK_HALF(8'(HALF))) parallel_rgb_lcd_port_i (
    .clock_i(clock_i), .rst_i(rst_i), .mode_i(mode), .pixel_i(pix),
    .ctl_i(ctl), .pixel_take_o(take), .pwm_channel_two_output_i(pwm),
    .backlight_on_i(bl), .panel_on_i(pn), .touch_reset_req_i(trq),
    .touch_event_in_i(irq), .touch_event_o(tev), .pixel_lines_o(lines),
    .line_sync_out_o(ls), .frame_sync_out_o(fs), .pixel_valid_out_o(pv),
    .pixel_clock_out_o(pclk), .backlight_dimming_pwm_o(pwm_o),
    .backlight_supply_on_o(bl_o), .panel_supply_on_o(pn_o),
    .touch_reset_n_o(trn));
  panel_model panel_model_i (.clock_i(clock_i), .rst_i(rst_i),
    .lines_i(lines), .ctl_i({ls, fs, pv}), .pclk_i(pclk), .irq_i(ev),
    .touch_event_in_o(irq), .got_o(got), .word_o(word), .per_o(per));
  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] s);
    tests_run++;
    if (e !== s)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, e, s);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [23:0] map(input logic [2:0] m,
    input rgb_port_pkg::pixel_s p);
    logic [7:0] r, g, b;
    r = p.red;
    g = p.green;
    b = p.blue;
    case (m)
      rgb_port_pkg::MODE_565_PACKED: map = {8'h00, r[7:3], g[7:2], b[7:3]};
      rgb_port_pkg::MODE_666_PACKED: map = {6'h00, r[7:2], g[7:2], b[7:2]};
      rgb_port_pkg::MODE_565_WIDE:
        map = {r[7:3], 3'h0, g[7:2], 2'h0, b[7:3], 3'h0};
      rgb_port_pkg::MODE_666_WIDE:
        map = {r[7:2], 2'h0, g[7:2], 2'h0, b[7:2], 2'h0};
      default: map = {r, g, b};
    endcase
  endfunction
  always @(posedge clock_i)
  begin
    cyc++;
    if (rst_i && cyc > 1)
      check("reset outputs", 0, {trn, pclk, pv, take, lines});
    if (!rst_i && take)
    begin
      takes++;
      exp_q.push_back({ctl, ctl.valid ? map(mode, pix) : 24'h000000});
      pix <= 24'($random(seed));
      ctl <= 3'($random(seed));
      mode <= cur_mode;
    end
    if (!rst_i && got && exp_q.size() > 0)
    begin
      check("pixel word", exp_q.pop_front(), word);
      check("pixel period", 2 * HALF, per);
    end
    if (cyc > 12)
      check("side band", {h3[4], h1[3:1], h3[0]},
        {pwm_o, bl_o, pn_o, ~trn, tev});
    h3 = h2;
    h2 = h1;
    h1 = {pwm, bl, pn, trq, irq};
    {pwm, bl, pn, trq, ev} <= 5'($random(seed));
  end
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial
  begin
    seed = 32'h90a4;
    {err_count, tests_run, cyc, takes} = 0;
    {h1, h2, h3} = 0;
    {pwm, bl, pn, trq, ev} = 5'h00;
    rst_i = 1'b1;
    mode = 3'h0;
    cur_mode = 3'h0;
    pix = 24'h A5C31E;
    ctl = 3'h7;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    // half of the eight passes use the 24-bit layout
    for (int m = 0; m < 8; m++)
    begin
      cur_mode <= 3'(m);
      takes = 0;
      for (int c = 0; c < 400 && takes < 30; c++)
        @(posedge clock_i);
      if (takes < 30)
      begin
        err_count++;
        $display("CHECK FAILED pixel take exp 30 got %0d", takes);
        break;
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
